// ==== hdl/nic_defines.vh ====
`ifndef NIC_DEFINES_VH
`define NIC_DEFINES_VH

// Byte offsets in the control and status space
`define OFF_SCB 5'h00
`define OFF_GPTR 5'h04
`define OFF_PORT 5'h08
`define OFF_EEFL 5'h0c
`define OFF_MDI 5'h10

// Status word field positions
`define ST_CX 15
`define ST_FR 14
`define ST_CNA 13
`define ST_RNR 12
`define ST_MDI 11
`define ST_CU_LSB 6
`define ST_RU_LSB 2

// Command word positions (within the upper half)
`define CMD_RU_LSB 0
`define CMD_CU_LSB 4
`define CMD_ACK_LSB 8

// Unit commands
`define UC_NOP 3'h0
`define UC_ACTIVATE 3'h1
`define UC_RESUME 3'h2
`define UC_SUSPEND 3'h3
`define UC_IDLE 3'h4

// Unit states
`define US_IDLE 2'h0
`define US_SUSP 2'h1
`define US_ACTIVE 2'h2

// Port functions
`define PF_SWRESET 4'h0
`define PF_SELFTEST 4'h1
`define PF_SELRESET 4'h2
`define PF_DUMP 4'h3

// Management control register fields
`define MDI_REG_LSB 16
`define MDI_PHY_LSB 21
`define MDI_OP_LSB 26
`define MDI_READY 28
`define MDI_IE 29
`define MDI_OP_READ 2'h2
`define MDI_OP_WRITE 2'h1

// Management frame layout
`define MF_START 2'h1
`define MF_TA_WRITE 2'h2
`define MF_LAST_BIT 7'd63
`define MF_RD_RELEASE 7'd46
`define MF_DATA_FIRST 7'd48

// Management clock timing
`define CLK_MHZ 125
`define MDC_HALF_NS 400
`define MDC_HALF_CYC ((`MDC_HALF_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== hdl/mgmt_frame.v ====
`timescale 1ns/1ps
`include "nic_defines.vh"

module mgmt_frame (
  input wire core_clk,
  input wire sys_rst,
  input wire clear,
  input wire start,
  input wire is_read,
  input wire [4:0] phy_address_field,
  input wire [4:0] phy_register_field,
  input wire [15:0] wdata,
  input wire mdio_i,
  output wire mdc,
  output wire mdio_o,
  output wire mdio_oe,
  output wire busy,
  output wire done,
  output wire [15:0] rdata
);

  localparam [31:0] HALF_CYC = `MDC_HALF_CYC;
  localparam [7:0] HALF_M1 = HALF_CYC[7:0] - 8'h01;

  reg [7:0] div_q;
  reg mdc_q;
  reg [6:0] bit_q;
  reg [63:0] sh_q;
  reg busy_q;
  reg rd_q;
  reg oe_q;
  reg o_q;
  reg done_q;
  reg [15:0] rdata_q;
  wire [1:0] op;
  wire [1:0] turnaround_bits;
  wire [63:0] frame;
  wire [6:0] bit_nx;

  assign op = is_read ? `MDI_OP_READ : `MDI_OP_WRITE;
  assign turnaround_bits = is_read ? 2'h0 : `MF_TA_WRITE;
  // Preamble, start, op, addresses, turnaround, data
  assign frame = {32'hffffffff, `MF_START, op, phy_address_field, phy_register_field,
                  turnaround_bits, wdata};
  assign bit_nx = bit_q + 7'd1;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 8'h00;
      mdc_q <= 1'b0;
      bit_q <= 7'h00;
      sh_q <= 64'h0;
      busy_q <= 1'b0;
      rd_q <= 1'b0;
      oe_q <= 1'b0;
      o_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      if (clear) begin
        busy_q <= 1'b0;
        oe_q <= 1'b0;
        mdc_q <= 1'b0;
        div_q <= 8'h00;
        rdata_q <= 16'h0000;
      end else if (!busy_q) begin
        oe_q <= 1'b0;
        if (start) begin
          busy_q <= 1'b1;
          sh_q <= frame;
          rd_q <= is_read;
          bit_q <= 7'h00;
          div_q <= 8'h00;
          mdc_q <= 1'b0;
          oe_q <= 1'b1;
          o_q <= frame[63];
        end
      end else if (div_q == HALF_M1) begin
        div_q <= 8'h00;
        mdc_q <= ~mdc_q;
        if (!mdc_q) begin
          // Rising edge: PHY samples our bit, we sample its data
          if (rd_q && bit_q >= `MF_DATA_FIRST) begin
            rdata_q <= {rdata_q[14:0], mdio_i};
          end
        end else if (bit_q == `MF_LAST_BIT) begin
          busy_q <= 1'b0;
          oe_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          // Falling edge: present next bit ahead of the rising edge
          bit_q <= bit_nx;
          sh_q <= {sh_q[62:0], 1'b0};
          o_q <= sh_q[62];
          oe_q <= !(rd_q && bit_nx >= `MF_RD_RELEASE);
        end
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  assign mdc = mdc_q;
  assign mdio_o = o_q;
  assign mdio_oe = oe_q;
  assign busy = busy_q;
  assign done = done_q;
  assign rdata = rdata_q;

endmodule // mgmt_frame

// ==== hdl/nic_csr.v ====
`timescale 1ns/1ps
`include "nic_defines.vh"

module nic_csr (
  input wire core_clk,
  input wire sys_rst,
  input wire host_wr,
  input wire host_rd,
  input wire host_io_cycle,
  input wire host_mem_cycle,
  input wire [4:0] host_addr,
  input wire [3:0] host_be,
  input wire [31:0] host_wdata,
  output wire [31:0] host_rdata,
  output wire host_ack,
  output wire scb_fetch,
  output wire cu_start,
  output wire cu_resume,
  output wire [31:0] unit_ptr,
  input wire cu_done,
  input wire cfg_done,
  output wire ru_start,
  input wire ru_frame_done,
  output wire rfd_advance,
  output wire tx_allow,
  output wire rx_allow,
  output wire [1:0] cu_state,
  output wire [1:0] ru_state,
  output wire status_irq,
  output wire port_op_start,
  output wire port_op_dump,
  output wire [27:0] port_addr,
  input wire port_op_done,
  output wire [15:0] eeprom_ctl,
  output wire [15:0] flash_ctl,
  output wire mdc,
  output wire mdio_o,
  output wire mdio_oe,
  input wire mdio_i
);

  localparam [1:0] P_IDLE = 2'd0, P_SEL = 2'd1, P_RUN = 2'd2, P_FULL = 2'd3;

  reg [4:0] stat_q, stat_d, mdi_reg_q, mdi_phy_q;
  reg [1:0] cu_q, cu_d, ru_q, ru_d, mdi_op_q, pst_q;
  reg [15:0] cmd_q, eeprom_q, flash_q, mdi_data_q;
  reg [31:0] gptr_q, rdata_q;
  reg [27:0] paddr_q;
  reg configured_q, fetch_q, cu_start_q, cu_resume_q, ru_start_q, rfd_adv_q, ack_q;
  reg mdi_ready_q, mdi_ie_q, mdi_go_q, pdump_q, pstart_q, full_clr_q, sel_clr_q;
  wire access, wr_scb, wr_cmd, wr_gptr, wr_port, wr_mdi, any_clr, mf_busy, mf_done;
  wire [3:0] pfunc;
  wire [15:0] mf_rdata;
  wire [31:0] cmd_merged;

  // Writes into one word, honouring byte enables
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  function hit;
    input [4:0] addr;
    input [4:0] off;
    begin
      hit = (addr[4:2] == off[4:2]);
    end
  endfunction

  // I/O and memory cycles decode to the same register set
  assign access = host_io_cycle | host_mem_cycle;
  assign wr_scb = host_wr & access & hit(host_addr, `OFF_SCB);
  assign wr_cmd = wr_scb & (host_be[2] | host_be[3]);
  assign wr_gptr = host_wr & access & hit(host_addr, `OFF_GPTR);
  assign wr_port = host_wr & access & hit(host_addr, `OFF_PORT) & host_be[0];
  assign wr_mdi = host_wr & access & hit(host_addr, `OFF_MDI) & !mf_busy & !mdi_go_q;
  assign pfunc = host_wdata[3:0];
  assign any_clr = full_clr_q | sel_clr_q;
  assign cmd_merged = merge({cmd_q, 16'h0000}, host_wdata, host_be);

  // Host read path and acknowledge
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= (host_wr | host_rd) & access;
      rdata_q <= 32'h00000000;
      if (host_rd & access) begin
        case (host_addr[4:2])
          3'd0: rdata_q <= {cmd_q, stat_q, 3'h0, cu_q, 2'h0, ru_q, 2'h0};
          3'd1: rdata_q <= gptr_q;
          3'd2: rdata_q <= {paddr_q, 4'h0};
          3'd3: rdata_q <= {eeprom_q, flash_q};
          3'd4: rdata_q <= {2'h0, mdi_ie_q, mdi_ready_q, mdi_op_q, mdi_phy_q,
                            mdi_reg_q, mdi_data_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Next unit states and status events
  always @* begin
    cu_d = cu_q;
    ru_d = ru_q;
    stat_d = stat_q;
    if (fetch_q) begin
      case (cmd_q[`CMD_CU_LSB +: 3])
        `UC_ACTIVATE: cu_d = `US_ACTIVE;
        `UC_RESUME: cu_d = (cu_q == `US_SUSP) ? `US_ACTIVE : cu_q;
        `UC_SUSPEND: cu_d = (cu_q == `US_ACTIVE) ? `US_SUSP : cu_q;
        `UC_IDLE: cu_d = `US_IDLE;
        default: cu_d = cu_q;
      endcase
      case (cmd_q[`CMD_RU_LSB +: 3])
        `UC_ACTIVATE: ru_d = `US_ACTIVE;
        `UC_RESUME: ru_d = (ru_q == `US_SUSP) ? `US_ACTIVE : ru_q;
        `UC_SUSPEND: ru_d = (ru_q == `US_ACTIVE) ? `US_SUSP : ru_q;
        `UC_IDLE: ru_d = `US_IDLE;
        default: ru_d = ru_q;
      endcase
    end
    if (cu_done && cu_q == `US_ACTIVE) begin
      cu_d = `US_IDLE;
    end
    // Acknowledge clears first so that new events win
    if (wr_cmd && host_be[3]) begin
      stat_d = stat_q & ~host_wdata[31:27];
    end
    if (cu_done && cu_q == `US_ACTIVE) begin
      stat_d[`ST_CX - 11] = 1'b1;
    end
    if (cu_q == `US_ACTIVE && cu_d != `US_ACTIVE) begin
      stat_d[`ST_CNA - 11] = 1'b1;
    end
    if (ru_q == `US_ACTIVE && ru_d != `US_ACTIVE) begin
      stat_d[`ST_RNR - 11] = 1'b1;
    end
    if (ru_frame_done && ru_q == `US_ACTIVE) begin
      stat_d[`ST_FR - 11] = 1'b1;
    end
    if (mf_done && mdi_ie_q) begin
      stat_d[`ST_MDI - 11] = 1'b1;
    end
  end

  // Control block and unit control
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= 5'h00;
      cu_q <= `US_IDLE;
      ru_q <= `US_IDLE;
      cmd_q <= 16'h0000;
      gptr_q <= 32'h00000000;
      configured_q <= 1'b0;
      fetch_q <= 1'b0;
      cu_start_q <= 1'b0;
      cu_resume_q <= 1'b0;
      ru_start_q <= 1'b0;
      rfd_adv_q <= 1'b0;
      eeprom_q <= 16'h0000;
      flash_q <= 16'h0000;
    end else if (any_clr) begin
      stat_q <= 5'h00;
      cu_q <= `US_IDLE;
      ru_q <= `US_IDLE;
      cmd_q <= 16'h0000;
      gptr_q <= 32'h00000000;
      fetch_q <= 1'b0;
      cu_start_q <= 1'b0;
      cu_resume_q <= 1'b0;
      ru_start_q <= 1'b0;
      rfd_adv_q <= 1'b0;
      eeprom_q <= 16'h0000;
      flash_q <= 16'h0000;
      if (full_clr_q) begin
        configured_q <= 1'b0;
      end
    end else begin
      stat_q <= stat_d;
      cu_q <= cu_d;
      ru_q <= ru_d;
      // A write anywhere in the block triggers a reread of all of it
      fetch_q <= wr_scb;
      if (wr_cmd) begin
        cmd_q <= cmd_merged[31:16];
      end else if (fetch_q) begin
        cmd_q[7:0] <= 8'h00;
      end
      if (wr_gptr) begin
        gptr_q <= merge(gptr_q, host_wdata, host_be);
      end
      if (host_wr && access && hit(host_addr, `OFF_EEFL)) begin
        {eeprom_q, flash_q} <= merge({eeprom_q, flash_q}, host_wdata, host_be);
      end
      cu_start_q <= fetch_q && cmd_q[`CMD_CU_LSB +: 3] == `UC_ACTIVATE;
      cu_resume_q <= fetch_q && cmd_q[`CMD_CU_LSB +: 3] == `UC_RESUME && cu_q == `US_SUSP;
      ru_start_q <= fetch_q && cmd_q[`CMD_RU_LSB +: 3] == `UC_ACTIVATE;
      rfd_adv_q <= ru_frame_done && ru_q == `US_ACTIVE;
      if (cfg_done) begin
        configured_q <= 1'b1;
      end
    end
  end

  // Port functions: resets, self-test, dump
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pst_q <= P_IDLE;
      paddr_q <= 28'h0000000;
      pdump_q <= 1'b0;
      pstart_q <= 1'b0;
      full_clr_q <= 1'b0;
      sel_clr_q <= 1'b0;
    end else begin
      full_clr_q <= 1'b0;
      sel_clr_q <= 1'b0;
      pstart_q <= 1'b0;
      case (pst_q)
        P_IDLE: begin
          if (wr_port) begin
            paddr_q <= host_wdata[31:4];
            case (pfunc)
              `PF_SWRESET: full_clr_q <= 1'b1;
              `PF_SELRESET: sel_clr_q <= 1'b1;
              `PF_SELFTEST, `PF_DUMP: begin
                sel_clr_q <= 1'b1;
                pdump_q <= (pfunc == `PF_DUMP);
                pst_q <= P_SEL;
              end
              default: pst_q <= P_IDLE;
            endcase
          end
        end
        P_SEL: begin
          pstart_q <= 1'b1;
          pst_q <= P_RUN;
        end
        P_RUN: begin
          if (port_op_done) begin
            pst_q <= P_FULL;
          end
        end
        P_FULL: begin
          full_clr_q <= 1'b1;
          pst_q <= P_IDLE;
        end
        default: pst_q <= P_IDLE;
      endcase
    end
  end

  // Management control register
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdi_data_q <= 16'h0000;
      mdi_reg_q <= 5'h00;
      mdi_phy_q <= 5'h00;
      mdi_op_q <= 2'h0;
      mdi_ready_q <= 1'b0;
      mdi_ie_q <= 1'b0;
      mdi_go_q <= 1'b0;
    end else if (any_clr) begin
      mdi_data_q <= 16'h0000;
      mdi_reg_q <= 5'h00;
      mdi_phy_q <= 5'h00;
      mdi_op_q <= 2'h0;
      mdi_ready_q <= 1'b0;
      mdi_ie_q <= 1'b0;
      mdi_go_q <= 1'b0;
    end else begin
      mdi_go_q <= 1'b0;
      if (wr_mdi) begin
        mdi_data_q <= host_wdata[15:0];
        mdi_reg_q <= host_wdata[`MDI_REG_LSB +: 5];
        mdi_phy_q <= host_wdata[`MDI_PHY_LSB +: 5];
        mdi_op_q <= host_wdata[`MDI_OP_LSB +: 2];
        mdi_ie_q <= host_wdata[`MDI_IE];
        mdi_ready_q <= 1'b0;
        mdi_go_q <= (host_wdata[`MDI_OP_LSB +: 2] == `MDI_OP_READ) ||
                    (host_wdata[`MDI_OP_LSB +: 2] == `MDI_OP_WRITE);
      end else if (mf_done) begin
        mdi_ready_q <= 1'b1;
        if (mdi_op_q == `MDI_OP_READ) begin
          mdi_data_q <= mf_rdata;
        end
      end
    end
  end

  mgmt_frame u_mgmt (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(any_clr),
    .start(mdi_go_q),
    .is_read(mdi_op_q == `MDI_OP_READ),
    .phy_address_field(mdi_phy_q),
    .phy_register_field(mdi_reg_q),
    .wdata(mdi_data_q),
    .mdio_i(mdio_i),
    .mdc(mdc),
    .mdio_o(mdio_o),
    .mdio_oe(mdio_oe),
    .busy(mf_busy),
    .done(mf_done),
    .rdata(mf_rdata)
  );

  assign host_rdata = rdata_q;
  assign host_ack = ack_q;
  assign scb_fetch = fetch_q;
  assign cu_start = cu_start_q;
  assign cu_resume = cu_resume_q;
  assign unit_ptr = gptr_q;
  assign ru_start = ru_start_q;
  assign rfd_advance = rfd_adv_q;
  assign tx_allow = configured_q && cu_q == `US_ACTIVE;
  assign rx_allow = configured_q && ru_q == `US_ACTIVE;
  assign cu_state = cu_q;
  assign ru_state = ru_q;
  assign status_irq = |stat_q;
  assign port_op_start = pstart_q;
  assign port_op_dump = pdump_q;
  assign port_addr = paddr_q;
  assign eeprom_ctl = eeprom_q;
  assign flash_ctl = flash_q;

endmodule // nic_csr

// ==== testbench/nic_csr_chk.sv ====
`timescale 1ns/1ps
`include "nic_defines.vh"

module nic_csr_chk (
  input wire core_clk,
  input wire sys_rst,
  input wire host_wr,
  input wire host_rd,
  input wire host_io_cycle,
  input wire host_mem_cycle,
  input wire [4:0] host_addr,
  input wire [31:0] host_rdata,
  input wire host_ack,
  input wire scb_fetch,
  input wire cu_start,
  input wire cu_done,
  input wire cfg_done,
  input wire ru_frame_done,
  input wire rfd_advance,
  input wire tx_allow,
  input wire rx_allow,
  input wire [1:0] cu_state,
  input wire [1:0] ru_state,
  input wire status_irq,
  input wire mdc,
  input wire mdio_o,
  input wire mdio_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire qual = (host_wr || host_rd) && (host_io_cycle || host_mem_cycle);
  logic mdc_q, oe_q, rd_q, cfg_q;
  logic [7:0] bit_q;
  // Frame bit index: count of management clock rises since driver enable
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_q <= 1'b0;
      oe_q <= 1'b0;
      rd_q <= 1'b0;
      cfg_q <= 1'b0;
      bit_q <= 8'hff;
    end else begin
      mdc_q <= mdc;
      oe_q <= mdio_oe;
      cfg_q <= cfg_q || cfg_done;
      if (mdio_oe && !oe_q) bit_q <= {7'h0, mdc && !mdc_q};
      else if (mdc && !mdc_q) bit_q <= bit_q + 8'h1;
      if (mdio_oe && !oe_q) rd_q <= 1'b0;
      else if (mdc && !mdc_q && mdio_oe && bit_q == 8'd34) rd_q <= mdio_o;
    end
  end
  sequence s_rise;
    $rose(mdc) && mdio_oe;
  endsequence
  property p_ack; qual |=> host_ack; endproperty
  a_ack: assert property (p_ack) else $error("strobe not acknowledged");
  property p_noack; !qual |=> !host_ack && host_rdata == 32'h0; endproperty
  a_noack: assert property (p_noack) else $error("ack without strobe");
  property p_fetch; host_wr && qual && host_addr[4:2] == 3'h0 |=> scb_fetch; endproperty
  a_fetch: assert property (p_fetch) else $error("no block fetch");
  property p_cu_act; cu_start |-> cu_state == `US_ACTIVE; endproperty
  a_cu_act: assert property (p_cu_act) else $error("cu not active");
  property p_cu_done;
    cu_done && cu_state == `US_ACTIVE |=> cu_state == `US_IDLE && status_irq;
  endproperty
  a_cu_done: assert property (p_cu_done) else $error("cu end wrong");
  property p_rfd; ru_frame_done && ru_state == `US_ACTIVE |=> rfd_advance; endproperty
  a_rfd: assert property (p_rfd) else $error("no descriptor advance");
  property p_allow; tx_allow || rx_allow |-> cfg_q; endproperty
  a_allow: assert property (p_allow) else $error("traffic before configure");
  property p_edge; mdio_oe && $past(mdio_oe) && $changed(mdio_o) |-> $fell(mdc); endproperty
  a_edge: assert property (p_edge) else $error("data moved off falling edge");
  property p_pre; s_rise ##0 (bit_q < 8'd32) |-> mdio_o; endproperty
  a_pre: assert property (p_pre) else $error("preamble bit low");
  property p_start; s_rise ##0 (bit_q == 8'd32) |-> !mdio_o; endproperty
  a_start: assert property (p_start) else $error("start bit wrong");
  property p_ta_rd; $rose(mdc) && rd_q && bit_q[7:1] == 7'd23 |-> !mdio_oe; endproperty
  a_ta_rd: assert property (p_ta_rd) else $error("driven in read turnaround");
  property p_ta_wr; s_rise ##0 (!rd_q && bit_q == 8'd46) |-> mdio_o; endproperty
  a_ta_wr: assert property (p_ta_wr) else $error("write turnaround wrong");
  property p_idle; $fell(mdc) && bit_q == 8'd64 |-> !mdio_oe; endproperty
  a_idle: assert property (p_idle) else $error("driver on after frame");
endmodule // nic_csr_chk

bind nic_csr nic_csr_chk u_chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .host_wr(host_wr),
  .host_rd(host_rd),
  .host_io_cycle(host_io_cycle),
  .host_mem_cycle(host_mem_cycle),
  .host_addr(host_addr),
  .host_rdata(host_rdata),
  .host_ack(host_ack),
  .scb_fetch(scb_fetch),
  .cu_start(cu_start),
  .cu_done(cu_done),
  .cfg_done(cfg_done),
  .ru_frame_done(ru_frame_done),
  .rfd_advance(rfd_advance),
  .tx_allow(tx_allow),
  .rx_allow(rx_allow),
  .cu_state(cu_state),
  .ru_state(ru_state),
  .status_irq(status_irq),
  .mdc(mdc),
  .mdio_o(mdio_o),
  .mdio_oe(mdio_oe)
);

// ==== testbench/phy_model.sv ====
`timescale 1ns/1ps

module phy_model (
  input wire sys_rst,
  input wire mdc,
  input wire line,
  input wire [15:0] rd_val,
  output logic phy_o,
  output logic phy_oe,
  output logic [1:0] got_op,
  output logic [4:0] got_phy,
  output logic [4:0] got_reg,
  output logic [1:0] got_ta,
  output logic [15:0] got_data,
  output logic [3:0] n_frames
);
  logic [6:0] p;
  logic [15:0] sr;
  wire [3:0] di = 4'he - p[3:0];
  always @(posedge mdc or posedge sys_rst) begin
    if (sys_rst) begin
      p <= 7'd0;
      sr <= 16'h0;
      got_op <= 2'h0;
      n_frames <= 4'h0;
    end else begin
      sr <= {sr[14:0], line};
      if (p == 7'd0) begin
        if (&sr[14:1] && !sr[0] && line) p <= 7'd33;
      end else if (p == 7'd62) begin
        p <= 7'd0;
        got_data <= {sr[14:0], line};
        n_frames <= n_frames + 4'h1;
      end else begin
        p <= p + 7'd1;
      end
      if (p == 7'd34) got_op <= {sr[0], line};
      if (p == 7'd39) got_phy <= {sr[3:0], line};
      if (p == 7'd44) got_reg <= {sr[3:0], line};
      if (p == 7'd46) got_ta <= {sr[0], line};
    end
  end
  // Float first turnaround bit, zero in second, then data MSB first
  always @(negedge mdc or posedge sys_rst) begin
    if (sys_rst) begin
      phy_oe <= 1'b0;
      phy_o <= 1'b0;
    end else begin
      phy_oe <= got_op == 2'b10 && p >= 7'd46 && p <= 7'd62;
      phy_o <= p != 7'd46 && rd_val[di];
    end
  end
endmodule // phy_model

// ==== testbench/nic_csr_test.sv ====
`timescale 1ns/1ps
`include "nic_defines.vh"

module nic_csr_test;
  logic core_clk = 1'b0, sys_rst = 1'b0, io_sel = 1'b0;
  logic host_wr = 1'b0, host_rd = 1'b0, host_io_cycle = 1'b0, host_mem_cycle = 1'b0;
  logic cu_done = 1'b0, cfg_done = 1'b0, ru_frame_done = 1'b0, port_op_done = 1'b0;
  logic [4:0] host_addr = 5'h00;
  logic [3:0] host_be = 4'hf;
  logic [31:0] host_wdata = 32'h0, v;
  wire [31:0] host_rdata, unit_ptr;
  wire host_ack, scb_fetch, cu_start, cu_resume, ru_start, rfd_advance, tx_allow, rx_allow;
  wire status_irq, port_op_start, port_op_dump, mdc, mdio_o, mdio_oe, mdio_i, phy_o, phy_oe;
  wire [1:0] cu_state, ru_state, got_op, got_ta;
  wire [27:0] port_addr;
  wire [15:0] eeprom_ctl, flash_ctl, got_data;
  wire [4:0] got_phy, got_reg;
  wire [3:0] n_frames;
  logic [3:0] n0;
  int n_mismatch = 0, checks_done = 0, cyc = 0, i, k;
  logic [2:0] ru_cmd [4] = '{`UC_ACTIVATE, `UC_SUSPEND, `UC_RESUME, `UC_IDLE};
  logic [1:0] ru_exp [4] = '{`US_ACTIVE, `US_SUSP, `US_ACTIVE, `US_IDLE};

  always #4 core_clk = ~core_clk;
  // Pull-up holds the line high when nobody drives
  assign mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);
  nic_csr DUT (.core_clk(core_clk), .sys_rst(sys_rst), .host_wr(host_wr), .host_rd(host_rd),
    .host_io_cycle(host_io_cycle), .host_mem_cycle(host_mem_cycle), .host_addr(host_addr),
    .host_be(host_be), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack),
    .scb_fetch(scb_fetch), .cu_start(cu_start), .cu_resume(cu_resume), .unit_ptr(unit_ptr),
    .cu_done(cu_done), .cfg_done(cfg_done), .ru_start(ru_start),
    .ru_frame_done(ru_frame_done), .rfd_advance(rfd_advance), .tx_allow(tx_allow),
    .rx_allow(rx_allow), .cu_state(cu_state), .ru_state(ru_state), .status_irq(status_irq),
    .port_op_start(port_op_start), .port_op_dump(port_op_dump), .port_addr(port_addr),
    .port_op_done(port_op_done), .eeprom_ctl(eeprom_ctl), .flash_ctl(flash_ctl),
    .mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio_i));
  phy_model PHY (.sys_rst(sys_rst), .mdc(mdc), .line(mdio_i), .rd_val(16'h9e61),
    .phy_o(phy_o), .phy_oe(phy_oe), .got_op(got_op), .got_phy(got_phy),
    .got_reg(got_reg), .got_ta(got_ta), .got_data(got_data), .n_frames(n_frames));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One-cycle strobe, alternating I/O and memory qualifiers
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    host_wr <= w;
    host_rd <= !w;
    host_io_cycle <= io_sel;
    host_mem_cycle <= !io_sel;
    host_addr <= a;
    host_wdata <= d;
    host_be <= be;
    @(posedge core_clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    io_sel <= !io_sel;
    #1;
    v = host_rdata;
    chk(host_ack, 1);
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [4:0] a);
    acc(1'b0, a, 32'h0, 4'hf);
  endtask
  task pulse(input int s);
    @(posedge core_clk);
    case (s)
      0: cu_done <= 1'b1;
      1: cfg_done <= 1'b1;
      2: ru_frame_done <= 1'b1;
      default: port_op_done <= 1'b1;
    endcase
    @(posedge core_clk);
    {cu_done, cfg_done, ru_frame_done, port_op_done} <= 4'h0;
    #1;
  endtask
  task wait_frame;
    n0 = n_frames;
    for (k = 0; k < 9000 && n_frames === n0; k++) step(1);
    chk(n_frames, n0 + 4'h1);
    step(60);
  endtask

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  initial begin
    #1 sys_rst = 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    step(1);
    rd(`OFF_SCB);
    chk(v, 32'h0);
    wr(5'h14, 32'hffff_ffff);
    rd(5'h14);
    chk(v, 32'h0);
    wr(`OFF_GPTR, 32'h1357_9bdf);
    rd(`OFF_GPTR);
    chk(v, 32'h1357_9bdf);
    chk(unit_ptr, 32'h1357_9bdf);
    acc(1'b1, `OFF_EEFL, 32'h1234_5678, 4'hc);
    rd(`OFF_EEFL);
    chk(v, 32'h1234_0000);
    chk({eeprom_ctl, flash_ctl}, 32'h1234_0000);
    wr(`OFF_SCB, 32'h0010_0000);
    step(1);
    chk(cu_state, `US_ACTIVE);
    chk(tx_allow, 0);
    pulse(0);
    chk(status_irq, 1);
    rd(`OFF_SCB);
    chk(v, 32'h0000_a000);
    wr(`OFF_SCB, 32'hf800_0000);
    step(1);
    chk(status_irq, 0);
    pulse(1);
    for (i = 0; i < 4; i++) begin
      wr(`OFF_SCB, {9'h0, ru_cmd[i], 1'b0, ru_cmd[i], 16'h0});
      step(1);
      chk({cu_state, ru_state}, {ru_exp[i], ru_exp[i]});
      chk({cu_start, ru_start, cu_resume}, {i == 0, i == 0, i == 2});
      if (i == 0) begin
        chk(rx_allow, 1);
        pulse(2);
        rd(`OFF_SCB);
        chk(v, 32'h0000_4088);
      end
    end
    wr(`OFF_SCB, 32'h0010_0000);
    step(1);
    chk(tx_allow, 1);
    wr(`OFF_PORT, {28'h0, `PF_SELRESET});
    step(2);
    rd(`OFF_GPTR);
    chk(v, 32'h0);
    wr(`OFF_SCB, 32'h0010_0000);
    step(1);
    chk(tx_allow, 1);
    wr(`OFF_PORT, {28'h0, `PF_SWRESET});
    step(2);
    wr(`OFF_SCB, 32'h0010_0000);
    step(1);
    chk(tx_allow, 0);
    for (i = 0; i < 2; i++) begin
      pulse(1);
      wr(`OFF_GPTR, 32'h2468_ace0);
      wr(`OFF_PORT, {28'h0abcdef, (i == 1) ? `PF_DUMP : `PF_SELFTEST});
      for (k = 0; k < 8 && port_op_start !== 1'b1; k++) step(1);
      chk(port_op_start, 1);
      chk(port_op_dump, i);
      chk(port_addr, 28'h0abcdef);
      rd(`OFF_GPTR);
      chk(v, 32'h0);
      pulse(3);
      step(1);
      wr(`OFF_SCB, 32'h0010_0000);
      step(1);
      chk(tx_allow, 0);
    end
    wr(`OFF_MDI, 32'h26aa_c35a);
    wait_frame();
    chk({got_op, got_phy, got_reg}, {2'b01, 5'h15, 5'h0a});
    chk({got_ta, got_data}, {2'b10, 16'hc35a});
    rd(`OFF_MDI);
    chk(v[28], 1);
    rd(`OFF_SCB);
    chk(v[11], 1);
    wr(`OFF_MDI, 32'h097f_0000);
    wait_frame();
    chk({got_op, got_phy, got_reg}, {2'b10, 5'h0b, 5'h1f});
    rd(`OFF_MDI);
    chk({v[28], v[15:0]}, {1'b1, 16'h9e61});
    finish_test();
  end
endmodule // nic_csr_test
